//--- vass_consts.vh
// Constants for the voltage ADC slot scheduler
`ifndef VASS_CONSTS_VH
`define VASS_CONSTS_VH

// Clock rate and slot times
`define VASS_CLK_MHZ        125
`define VASS_SLOT_US        3000
`define VASS_FAST_SLOT_US   1500

// Loop structure
`define VASS_NUM_CELLS      16
`define VASS_BASE_SLOTS     5'h12
`define VASS_MAX_AUX_SLOTS  2'h3
`define VASS_NUM_AUX        9
`define VASS_ROT_LAST       2'h2

// Source codes on the converter multiplexer
`define VASS_SRC_TOP_CELL   5'h10
`define VASS_SRC_PACK       5'h11
`define VASS_SRC_LOAD       5'h12
`define VASS_SRC_INT_TEMP   5'h13
`define VASS_SRC_REG_RAIL   5'h14
`define VASS_SRC_GROUND     5'h15
`define VASS_SRC_AUX0       5'h16
`define VASS_SRC_LAST       5'h1E
`define VASS_NUM_SRC        31

// Slot positions inside a loop
`define VASS_SLOT_PIN       5'h10
`define VASS_SLOT_INT       5'h11

// Cell clip level, five times the first internal reference in raw counts
`define VASS_CELL_CLIP_CODE 24'h60_0000

// Fixed-point shift of the gain trim (Q0.16)
`define VASS_GAIN_SHIFT     16

`endif

//--- vass_corrector.v
// Trim, calibration and clip stage for one converter result
`timescale 1ns/1ps
`include "vass_consts.vh"

module vass_corrector
(
    input  wire        sys_clk_in,    // System clock
    input  wire        rst_n_in,      // Synchronous reset, active low
    input  wire        valid_in,      // Raw result present, one-cycle pulse
    input  wire [23:0] raw_in,        // Raw signed converter code
    input  wire        is_cell_in,    // Result belongs to a cell slot
    input  wire [15:0] gain_in,       // Gain trim, unsigned Q0.16
    input  wire [15:0] offset_in,     // Offset trim in mV, signed
    output reg         valid_out,     // Corrected result present
    output reg  [23:0] raw_out,       // Raw code after clipping
    output reg  [15:0] mv_out         // Corrected value in mV
);

    // Signed views of the inputs
    wire signed [23:0] raw_s    = raw_in;
    wire signed [23:0] clip_s   = `VASS_CELL_CLIP_CODE;
    wire signed [15:0] offset_s = offset_in;

    // Cell codes never exceed the clip level
    wire signed [23:0] code_s = (is_cell_in && (raw_s > clip_s)) ? clip_s : raw_s;

    // Gain applied as a 41-bit product; top bit is never needed after scaling
    wire signed [40:0] prod_s   = code_s * $signed({1'b0, gain_in});
    wire signed [23:0] scaled_s = prod_s[39:16];
    wire signed [24:0] sum_s    = scaled_s + offset_s;

    // Saturate into the 16-bit signed millivolt field
    reg [15:0] mv_sat;

    // Saturation keeps a wild code from wrapping to the opposite sign
    always @*
    begin
        if (sum_s > 25'sd32767)
            mv_sat = 16'h7FFF;
        else if (sum_s < -25'sd32768)
            mv_sat = 16'h8000;
        else
            mv_sat = sum_s[15:0];
    end

    // Registered result, one cycle after the raw code
    always @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            valid_out <= 1'b0;
            raw_out   <= 24'h00_0000;
            mv_out    <= 16'h0000;
        end
        else
        begin
            valid_out <= valid_in;
            if (valid_in)
            begin
                raw_out <= code_s;
                mv_out  <= mv_sat;
            end
        end
    end

endmodule // vass_corrector

//--- vass_scheduler.v
// Slot sequencer and result store for the multiplexed voltage converter
// Function
// - One converter muxed over all voltage sources
// - Cell n measured between inputs n+1, n
// - Cells corrected, published as 16-bit millivolts
// - Raw 24-bit code kept, read as 32-bit
// - Cell codes clip at five reference volts
// - Sixteen cells, pin, internal, then aux slots
// - Shared slots rotate; full set every three loops
// - Slots per loop: 18 plus up to three
// - Slot lasts 3 ms, or 1.5 ms fast
// - Slower loop appends idle slots after measurements
// - Every cell input published in both forms
`timescale 1ns/1ps
`include "vass_consts.vh"

module vass_scheduler
#(
    parameter SLOT_CYC      = `VASS_SLOT_US * `VASS_CLK_MHZ,      // Normal slot length
    parameter FAST_SLOT_CYC = `VASS_FAST_SLOT_US * `VASS_CLK_MHZ  // Fast slot length
)
(
    input  wire        sys_clk_in,        // System clock, 125 MHz
    input  wire        rst_n_in,          // Synchronous reset, active low
    input  wire        meas_enable_in,    // Run the measurement loop
    input  wire        fast_conv_in,      // Select the short slot
    input  wire [7:0]  idle_slots_in,     // Idle slots appended per loop
    input  wire [8:0]  aux_enable_in,     // Enabled thermistor or general inputs
    input  wire [15:0] gain_in,           // Gain trim, Q0.16
    input  wire [15:0] offset_in,         // Offset trim in mV
    input  wire        conv_done_in,      // Converter result ready, pulse
    input  wire [23:0] conv_data_in,      // Converter raw code
    input  wire [4:0]  rd_src_in,         // Source picked for readout
    output reg         conv_start_out,    // Start a conversion, pulse
    output reg  [4:0]  mux_src_out,       // Source on the multiplexer
    output reg  [4:0]  cell_pos_idx_out,  // Upper cell_sense_input of the pair
    output reg  [4:0]  cell_neg_idx_out,  // Lower cell_sense_input of the pair
    output reg  [15:0] rd_mv_out,         // Published mV of picked source
    output reg  [31:0] rd_raw_out,        // Published raw of picked source
    output reg         result_valid_out,  // A result was stored, pulse
    output reg  [4:0]  result_src_out,    // Source of the stored result
    output reg  [4:0]  slot_idx_out,      // Slot index within the loop
    output reg         idle_slot_out,     // Current slot is idle
    output reg         set_done_out       // Full measurement set complete, pulse
);

    // Run states
    localparam ST_OFF = 1'b0;
    localparam ST_RUN = 1'b1;

    reg        state_r;         // Run state
    reg [18:0] tmr_r;           // Cycles into the current slot
    reg [8:0]  slot_r;          // Slot index, idle slots included
    reg [4:0]  meas_slots_r;    // Measurement slots this loop
    reg [8:0]  total_slots_r;   // All slots this loop
    reg        fast_r;          // Slot length latched per loop
    reg [1:0]  rot_r;           // Rotation of the shared slots
    reg [3:0]  aux_ptr_r;       // Round-robin search start
    reg        wide_aux_r;      // More aux inputs than aux slots
    reg        pending_r;       // Waiting for the converter
    reg [4:0]  wr_src_r;        // Source of the result in flight

    // Published results, flip-flop storage indexed by source
    reg [15:0] mv_mem  [0:`VASS_NUM_SRC-1];
    reg [23:0] raw_mem [0:`VASS_NUM_SRC-1];

    integer i;

    // Count of enabled aux inputs
    function [3:0] pop9;
        input [8:0] m;
        integer k;
        begin
            pop9 = 4'h0;
            for (k = 0; k < `VASS_NUM_AUX; k = k + 1)
                pop9 = pop9 + {3'b000, m[k]};
        end
    endfunction

    // First enabled aux input at or after start, wrapping
    function [3:0] next_aux;
        input [8:0] m;
        input [3:0] start;
        integer k;
        reg     found;
        reg [4:0] idx;
        begin
            found    = 1'b0;
            next_aux = start;
            for (k = 0; k < `VASS_NUM_AUX; k = k + 1)
            begin
                idx = {1'b0, start} + k[4:0];
                if (idx >= `VASS_NUM_AUX)
                    idx = idx - 5'h09;
                if (!found && m[idx[3:0]])
                begin
                    found    = 1'b1;
                    next_aux = idx[3:0];
                end
            end
        end
    endfunction

    // Loop configuration derived from the live inputs
    wire [3:0] aux_cnt   = pop9(aux_enable_in);
    wire       aux_wide  = (aux_cnt > {2'b00, `VASS_MAX_AUX_SLOTS});
    wire [1:0] aux_slots = aux_wide ? `VASS_MAX_AUX_SLOTS : aux_cnt[1:0];
    wire [4:0] meas_nxt  = `VASS_BASE_SLOTS + {3'b000, aux_slots};
    wire [8:0] total_nxt = {4'h0, meas_nxt} + {1'b0, idle_slots_in};

    // Slot end at the latched length
    wire [18:0] slot_len = fast_r ? FAST_SLOT_CYC[18:0] : SLOT_CYC[18:0];
    wire        slot_end = (tmr_r == slot_len - 19'd1);
    wire        last_slot = (slot_r == total_slots_r - 9'd1);

    // Aux input chosen for the current aux slot
    wire [3:0] aux_pick = next_aux(aux_enable_in, aux_ptr_r);
    wire [3:0] aux_nxt  = (aux_pick == 4'd8) ? 4'd0 : aux_pick + 4'd1;

    // Source of the current slot, fixed order within the loop
    reg [4:0] slot_src;

    // Cells first, then pin, internal, aux
    always @*
    begin
        if (slot_r < `VASS_NUM_CELLS)
            slot_src = slot_r[4:0];
        else if (slot_r == {4'h0, `VASS_SLOT_PIN})
            slot_src = `VASS_SRC_TOP_CELL + {3'b000, rot_r};
        else if (slot_r == {4'h0, `VASS_SLOT_INT})
            slot_src = `VASS_SRC_INT_TEMP + {3'b000, rot_r};
        else
            slot_src = `VASS_SRC_AUX0 + {1'b0, aux_pick};
    end

    wire meas_slot = (slot_r < {4'h0, meas_slots_r});
    wire slot_go   = (state_r == ST_RUN) && (tmr_r == 19'd0) && meas_slot;

    // Corrected result from the trim stage
    wire        corr_valid;
    wire [23:0] corr_raw;
    wire [15:0] corr_mv;

    // Correction and clip stage
    vass_corrector vass_corrector_inst
    (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .valid_in   (conv_done_in && pending_r),
        .raw_in     (conv_data_in),
        .is_cell_in (wr_src_r < `VASS_NUM_CELLS),
        .gain_in    (gain_in),
        .offset_in  (offset_in),
        .valid_out  (corr_valid),
        .raw_out    (corr_raw),
        .mv_out     (corr_mv)
    );

    // Sequencer: slot timer, slot index, rotation and aux pointer
    always @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_r        <= ST_OFF;
            tmr_r          <= 19'd0;
            slot_r         <= 9'd0;
            meas_slots_r   <= `VASS_BASE_SLOTS;
            total_slots_r  <= {4'h0, `VASS_BASE_SLOTS};
            fast_r         <= 1'b0;
            rot_r          <= 2'd0;
            aux_ptr_r      <= 4'd0;
            wide_aux_r     <= 1'b0;
            set_done_out   <= 1'b0;
        end
        else
        begin
            set_done_out <= 1'b0;
            case (state_r)
                ST_OFF:
                begin
                    // Latch configuration for the first loop
                    if (meas_enable_in)
                    begin
                        state_r       <= ST_RUN;
                        tmr_r         <= 19'd0;
                        slot_r        <= 9'd0;
                        meas_slots_r  <= meas_nxt;
                        total_slots_r <= total_nxt;
                        fast_r        <= fast_conv_in;
                        wide_aux_r    <= aux_wide;
                        rot_r         <= 2'd0;
                        aux_ptr_r     <= 4'd0;
                    end
                end
                ST_RUN:
                begin
                    // Advance the aux pointer as each aux slot begins
                    if (slot_go && (slot_r > {4'h0, `VASS_SLOT_INT}))
                        aux_ptr_r <= aux_nxt;
                    if (!slot_end)
                        tmr_r <= tmr_r + 19'd1;
                    else if (!last_slot)
                    begin
                        tmr_r  <= 19'd0;
                        slot_r <= slot_r + 9'd1;
                    end
                    else
                    begin
                        // Loop boundary: stop, or repeat with fresh settings
                        tmr_r  <= 19'd0;
                        slot_r <= 9'd0;
                        if (!meas_enable_in)
                            state_r <= ST_OFF;
                        meas_slots_r  <= meas_nxt;
                        total_slots_r <= total_nxt;
                        fast_r        <= fast_conv_in;
                        wide_aux_r    <= aux_wide;
                        // Few aux inputs are all measured every loop
                        if (!aux_wide)
                            aux_ptr_r <= 4'd0;
                        // Third loop closes a full set
                        if (rot_r == `VASS_ROT_LAST)
                        begin
                            rot_r        <= 2'd0;
                            set_done_out <= 1'b1;
                        end
                        else
                            rot_r <= rot_r + 2'd1;
                    end
                end
                default:
                    state_r <= ST_OFF;
            endcase
        end
    end

    // Converter control: start pulse and multiplexer selection
    always @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            conv_start_out   <= 1'b0;
            mux_src_out      <= 5'h00;
            cell_pos_idx_out <= 5'h00;
            cell_neg_idx_out <= 5'h00;
            pending_r        <= 1'b0;
            wr_src_r         <= 5'h00;
            slot_idx_out     <= 5'h00;
            idle_slot_out    <= 1'b0;
        end
        else
        begin
            conv_start_out <= slot_go;
            slot_idx_out   <= meas_slot ? slot_r[4:0] : 5'h1F;
            idle_slot_out  <= (state_r == ST_RUN) && !meas_slot;
            if (slot_go)
            begin
                mux_src_out <= slot_src;
                wr_src_r    <= slot_src;
                pending_r   <= 1'b1;
                // Cell n sits between input n+1 and input n
                if (slot_src < `VASS_NUM_CELLS)
                begin
                    cell_pos_idx_out <= slot_src + 5'h01;
                    cell_neg_idx_out <= slot_src;
                end
                else
                begin
                    cell_pos_idx_out <= 5'h00;
                    cell_neg_idx_out <= 5'h00;
                end
            end
            else if (conv_done_in)
                pending_r <= 1'b0;
        end
    end

    // Result store: newest value replaces the old one
    always @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            for (i = 0; i < `VASS_NUM_SRC; i = i + 1)
            begin
                mv_mem[i]  <= 16'h0000;
                raw_mem[i] <= 24'h00_0000;
            end
            result_valid_out <= 1'b0;
            result_src_out   <= 5'h00;
        end
        else
        begin
            result_valid_out <= corr_valid;
            if (corr_valid)
            begin
                mv_mem[wr_src_r]  <= corr_mv;
                raw_mem[wr_src_r] <= corr_raw;
                result_src_out    <= wr_src_r;
            end
        end
    end

    // Readout, raw sign-extended to 32 bits
    always @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            rd_mv_out  <= 16'h0000;
            rd_raw_out <= 32'h0000_0000;
        end
        else if (rd_src_in > `VASS_SRC_LAST)
        begin
            // Unused code reads as zero
            rd_mv_out  <= 16'h0000;
            rd_raw_out <= 32'h0000_0000;
        end
        else
        begin
            rd_mv_out  <= mv_mem[rd_src_in];
            rd_raw_out <= {{8{raw_mem[rd_src_in][23]}}, raw_mem[rd_src_in]};
        end
    end

endmodule // vass_scheduler

//--- vass_scheduler_properties.sv
// Port assertions for the slot scheduler
`timescale 1ns/1ps
module vass_sched_props
(
    input wire logic        sys_clk_in,       // Clock
    input wire logic        rst_n_in,         // Reset, low
    input wire logic        conv_start_out,   // Start pulse
    input wire logic [4:0]  mux_src_out,      // Source
    input wire logic [4:0]  cell_pos_idx_out, // Upper input
    input wire logic [4:0]  cell_neg_idx_out, // Lower input
    input wire logic        conv_done_in,     // Result ready
    input wire logic        result_valid_out, // Result stored
    input wire logic [4:0]  rd_src_in,        // Readout pick
    input wire logic [31:0] rd_raw_out,       // Raw readout
    input wire logic [4:0]  slot_idx_out,     // Slot index
    input wire logic        idle_slot_out,    // Idle slot
    input wire logic        set_done_out      // Set complete
);
    // Single domain, so one default clock
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Start followed by the converter answer
    sequence s_conv;
        conv_start_out ##[1:40] conv_done_in;
    endsequence
    property p_store;
        s_conv |-> ##2 result_valid_out;
    endproperty
    property p_valid;
        result_valid_out |-> $past(conv_done_in, 2);
    endproperty
    // Fast slot is ten cycles in this bench
    property p_gap;
        conv_start_out |=> !conv_start_out [*8];
    endproperty
    property p_pair;
        conv_start_out && mux_src_out < 5'h10 |->
            cell_pos_idx_out == mux_src_out + 5'h01 && cell_neg_idx_out == mux_src_out;
    endproperty
    property p_cells;
        conv_start_out && slot_idx_out < 5'h10 |-> mux_src_out == slot_idx_out;
    endproperty
    property p_pin;
        conv_start_out && slot_idx_out == 5'h10 |-> mux_src_out inside {5'h10, 5'h11, 5'h12};
    endproperty
    property p_int;
        conv_start_out && slot_idx_out == 5'h11 |-> mux_src_out inside {5'h13, 5'h14, 5'h15};
    endproperty
    property p_aux;
        conv_start_out && slot_idx_out > 5'h11 |->
            slot_idx_out < 5'h15 && mux_src_out > 5'h15 && mux_src_out < 5'h1F;
    endproperty
    property p_idle;
        idle_slot_out |-> slot_idx_out == 5'h1F && !conv_start_out;
    endproperty
    property p_sign;
        rd_raw_out[31:24] == {8{rd_raw_out[23]}};
    endproperty
    // Readout lags the pick by one cycle
    property p_clip;
        $past(rd_src_in) < 5'h10 |-> $signed(rd_raw_out[23:0]) <= $signed(24'h60_0000);
    endproperty
    property p_set;
        set_done_out |=> !set_done_out [*8];
    endproperty
    a_store: assert property (p_store) else $error("result not stored");
    a_valid: assert property (p_valid) else $error("stray store");
    a_gap: assert property (p_gap) else $error("slot too short");
    a_pair: assert property (p_pair) else $error("wrong input pair");
    a_cells: assert property (p_cells) else $error("cell order");
    a_pin: assert property (p_pin) else $error("pin slot source");
    a_int: assert property (p_int) else $error("internal slot source");
    a_aux: assert property (p_aux) else $error("aux slot");
    a_idle: assert property (p_idle) else $error("idle slot");
    a_sign: assert property (p_sign) else $error("raw not extended");
    a_clip: assert property (p_clip) else $error("cell not clipped");
    a_set: assert property (p_set) else $error("set pulse");
endmodule // vass_sched_props

//--- vass_conv_model.sv
// Behavioural converter with source-dependent codes
`timescale 1ns/1ps
module vass_conv_model
(
    input  wire logic        sys_clk_in,    // Clock
    input  wire logic        rst_n_in,      // Reset, low
    input  wire logic        conv_start_in, // Start pulse
    input  wire logic [4:0]  mux_src_in,    // Selected source
    input  wire logic [7:0]  latency_in,    // Answer delay, at least 1
    input  wire logic [23:0] data_add_in,   // Shift added to every code
    output logic             conv_done_out, // Result pulse
    output logic [23:0]      conv_data_out  // Result code
);
    logic [7:0] cnt_r; // Cycles to answer
    logic [4:0] src_r; // Source under conversion
    // One conversion at a time; a new start drops the old one
    always @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            cnt_r <= 8'h00;
            src_r <= 5'h00;
            conv_done_out <= 1'b0;
            conv_data_out <= 24'h00_0000;
        end
        else
        begin
            conv_done_out <= 1'b0;
            // Data toggles outside the result cycle
            conv_data_out <= ~conv_data_out;
            if (conv_start_in)
            begin
                cnt_r <= latency_in;
                src_r <= mux_src_in;
            end
            else if (cnt_r != 8'h00)
            begin
                cnt_r <= cnt_r - 8'h01;
                if (cnt_r == 8'h01)
                begin
                    conv_done_out <= 1'b1;
                    // Over-range on cell 15 and top cell, negative on cell 1
                    conv_data_out <= data_add_in + ((src_r == 5'h0F || src_r == 5'h10) ?
                        24'h7F_0000 : (src_r == 5'h01) ? 24'hFF_FF00 :
                        24'h00_0100 * ({19'h0_0000, src_r} + 24'h00_0001));
                end
            end
        end
    end
endmodule // vass_conv_model

//--- voltage_adc_slot_scheduler_test.sv
// Self-checking bench for the slot scheduler
`timescale 1ns/1ps
module voltage_adc_slot_scheduler_test;
    logic        sys_clk_in, rst_n_in, meas_enable_in, fast_conv_in, conv_done_in;
    logic        conv_start_out, result_valid_out, idle_slot_out, set_done_out;
    logic [7:0]  idle_slots_in, lat;
    logic [8:0]  aux_enable_in;
    logic [23:0] conv_data_in, add;
    logic [4:0]  rd_src_in, mux_src_out, cell_pos_idx_out, cell_neg_idx_out;
    logic [4:0]  result_src_out, slot_idx_out;
    logic [15:0] rd_mv_out;
    logic [31:0] rd_raw_out;
    integer      num_errors, compares, n, cyc, rot, seen, last, dn;
    // Short slots keep the run brief
    vass_scheduler #(.SLOT_CYC(20), .FAST_SLOT_CYC(10)) vass_scheduler_inst (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .meas_enable_in(meas_enable_in),
        .fast_conv_in(fast_conv_in), .idle_slots_in(idle_slots_in),
        .aux_enable_in(aux_enable_in), .gain_in(16'h8000), .offset_in(16'h0005),
        .conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .rd_src_in(rd_src_in),
        .conv_start_out(conv_start_out), .mux_src_out(mux_src_out),
        .cell_pos_idx_out(cell_pos_idx_out), .cell_neg_idx_out(cell_neg_idx_out),
        .rd_mv_out(rd_mv_out), .rd_raw_out(rd_raw_out), .result_valid_out(result_valid_out),
        .result_src_out(result_src_out), .slot_idx_out(slot_idx_out),
        .idle_slot_out(idle_slot_out), .set_done_out(set_done_out));
    vass_conv_model vass_conv_model_inst (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .conv_start_in(conv_start_out),
        .mux_src_in(mux_src_out), .latency_in(lat), .data_add_in(add),
        .conv_done_out(conv_done_in), .conv_data_out(conv_data_in));
    // 125 MHz clock
    initial
    begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    task chk(input [31:0] s, input [31:0] e);
        compares = compares + 1;
        if (s !== e)
        begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task test_done;
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Next enabled aux input after l, wrapping
    function integer nxt(input integer l);
        integer i;
        nxt = 0;
        for (i = 9; i > 0; i--)
            if (aux_enable_in[(l + i) % 9]) nxt = (l + i) % 9;
    endfunction
    // Skip the current edge, then find a loop start
    task wait_start;
        integer g;
        g = 0;
        @(negedge sys_clk_in);
        while (g < 2000 && !(conv_start_out === 1'b1 && slot_idx_out === 5'h00))
        begin
            @(negedge sys_clk_in);
            g++;
        end
        if (g == 2000) chk(g, 0);
    endtask
    // Walk one loop from its start to the next start
    task meas_loop;
        integer g, s;
        n = 0;
        cyc = 0;
        g = 0;
        if ($countones(aux_enable_in) <= 3) last = -1;
        while (g < 2000 && !(n > 0 && conv_start_out === 1'b1 && slot_idx_out === 5'h00))
        begin
            if (conv_start_out === 1'b1)
            begin
                s = mux_src_out;
                if (n < 16) chk(s, n);
                else if (n == 16)
                begin
                    rot = s - 16;
                    seen = seen | (1 << rot);
                end
                else if (n == 17) chk(s, 19 + rot);
                else if (last == -2) last = s - 22;
                else
                begin
                    last = nxt(last);
                    chk(s, 22 + last);
                end
                n++;
            end
            if (set_done_out === 1'b1) dn++;
            if (result_valid_out === 1'b1) chk(result_src_out, s);
            @(negedge sys_clk_in);
            cyc++;
            g++;
        end
    endtask
    // Run nl loops of one setup and time them
    task t_loop(input [8:0] a, input f, input [7:0] il, input integer sl, input integer nl);
        @(negedge sys_clk_in);
        aux_enable_in = a;
        fast_conv_in = f;
        idle_slots_in = il;
        last = -2;
        wait_start;
        repeat (nl)
        begin
            meas_loop;
            chk(n, sl);
            chk(cyc, (sl + il) * (f ? 10 : 20));
        end
    endtask
    // Read back published results against the model codes
    task t_read(input integer ns);
        integer s, v;
        logic [23:0] c;
        for (s = 0; s < ns; s++)
        begin
            c = (s == 15 || s == 16) ? 24'h7F_0000 : (s == 1) ? 24'hFF_FF00 :
                24'h00_0100 * (s + 1);
            c = c + add;
            if (s < 16 && $signed(c) > $signed(24'h60_0000)) c = 24'h60_0000;
            v = ($signed(c) >>> 1) + 5;
            if (v > 32767) v = 32767;
            @(negedge sys_clk_in);
            rd_src_in = s;
            @(negedge sys_clk_in);
            chk(rd_raw_out, {{8{c[23]}}, c});
            if (s < 16) chk(rd_mv_out, v[15:0]);
        end
    endtask
    // Cleared store after reset; first start two cycles after enable
    task t_start;
        @(negedge sys_clk_in);
        chk(rd_raw_out, 0);
        chk(slot_idx_out, 5'h00);
        meas_enable_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        chk(conv_start_out, 1);
    endtask
    // Unused pick reads zero; loop halts once disabled
    task t_stop;
        @(negedge sys_clk_in);
        rd_src_in = 5'h1F;
        @(negedge sys_clk_in);
        chk(rd_raw_out, 0);
        chk(rd_mv_out, 0);
        meas_enable_in = 1'b0;
        repeat (600) @(negedge sys_clk_in);
        n = 0;
        repeat (100)
        begin
            @(negedge sys_clk_in);
            if (conv_start_out === 1'b1) n++;
        end
        chk(n, 0);
        chk(slot_idx_out, 5'h00);
    endtask
    // Hang guard
    initial
    begin
        repeat (60000) @(posedge sys_clk_in);
        num_errors = num_errors + 1;
        test_done;
    end
    initial
    begin
        num_errors = 0;
        compares = 0;
        rst_n_in = 1'b0;
        meas_enable_in = 1'b0;
        fast_conv_in = 1'b0;
        idle_slots_in = 8'h00;
        aux_enable_in = 9'h000;
        rd_src_in = 5'h00;
        lat = 8'h03;
        add = 24'h00_0000;
        repeat (8) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        t_start;
        // Slot counts, slot lengths and idle slots
        t_loop(9'h000, 1'b0, 8'h00, 18, 1);
        t_loop(9'h001, 1'b1, 8'h00, 19, 1);
        t_loop(9'h003, 1'b0, 8'h02, 20, 1);
        t_loop(9'h1C0, 1'b1, 8'h00, 21, 1);
        t_loop(9'h01F, 1'b0, 8'h01, 21, 3);
        // Full set every three loops
        dn = 0;
        seen = 0;
        t_loop(9'h000, 1'b1, 8'h00, 18, 3);
        chk(seen, 7);
        chk(dn, 1);
        t_read(17);
        // Slow answers and new codes overwrite old ones
        add = 24'h00_0200;
        lat = 8'h0F;
        t_loop(9'h000, 1'b0, 8'h00, 18, 1);
        t_read(16);
        t_stop;
        test_done;
    end
endmodule // voltage_adc_slot_scheduler_test
bind vass_scheduler vass_sched_props vass_sched_props_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .conv_start_out(conv_start_out),
    .mux_src_out(mux_src_out), .cell_pos_idx_out(cell_pos_idx_out),
    .cell_neg_idx_out(cell_neg_idx_out), .conv_done_in(conv_done_in),
    .result_valid_out(result_valid_out), .rd_src_in(rd_src_in), .rd_raw_out(rd_raw_out),
    .slot_idx_out(slot_idx_out), .idle_slot_out(idle_slot_out), .set_done_out(set_done_out));
